// >>> hw/tlbr_debug_readout.sv
// translation cache debug readout on the secure programming port
`timescale 1ns/1ps
`include "tlbr_cfg.svh"
module tlbr_debug_readout
    import tlbr_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int ID_W = 4,
    parameter int NUM_UNITS = 8,
    parameter int BU_ENTRIES = 64,
    parameter int TC_ENTRIES = 512
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [ID_W-1:0] awid,
    input wire logic [2:0] awprot,
    // write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    output logic [ID_W-1:0] bid,
    // read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [ID_W-1:0] arid,
    input wire logic [2:0] arprot,
    // read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic [ID_W-1:0] rid,
    output logic rlast,
    // cache read port, data one cycle after the request
    output logic cache_req,
    output tlbr_fetch_t cache_fetch,
    input wire tlbr_entry_t cache_entry
);

    tlbr_state_t state, next_state;
    tlbr_bu_ptr_t bu_ptr, next_bu_ptr;
    tlbr_tc_ptr_t tc_ptr, next_tc_ptr;
    tlbr_fetch_t next_fetch;
    logic oob, next_oob;
    logic rsel_fmt, next_rsel_fmt;
    logic [31:0] rreg, next_rreg;
    logic [1:0] next_rresp, next_bresp;
    logic [ID_W-1:0] next_rid, next_bid;
    logic next_bvalid;
    logic wr_pend, wr_take, ar_take, wr_sec, rd_sec;
    logic [31:0] fmt_word;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[8*i +: 8] = din[8*i +: 8];
            end
        end
        return m & `TLBR_LOW_MASK;
    endfunction

    // a write and a read never share a cycle, so a pointer has one updater at a time
    assign wr_pend = awvalid && wvalid && !bvalid;
    assign wr_take = ce && state == TLBR_IDLE && wr_pend;
    assign ar_take = ce && state == TLBR_IDLE && arvalid && !wr_pend;
    assign awready = wr_take;
    assign wready = wr_take;
    assign arready = ar_take;
    assign wr_sec = !awprot[`TLBR_PROT_NS];
    assign rd_sec = !arprot[`TLBR_PROT_NS];
    assign rvalid = state == TLBR_RESP;
    assign rlast = 1'b1;
    assign rdata = rsel_fmt ? fmt_word : rreg;
    assign cache_req = ce && state == TLBR_FETCH;

    always_comb begin
        next_state = state;
        next_bu_ptr = bu_ptr;
        next_tc_ptr = tc_ptr;
        next_fetch = cache_fetch;
        next_oob = oob;
        next_rsel_fmt = rsel_fmt;
        next_rreg = rreg;
        next_rresp = rresp;
        next_rid = rid;
        next_bvalid = bvalid && !bready;
        next_bresp = bresp;
        next_bid = bid;
        if (wr_take) begin
            next_bvalid = 1'b1;
            next_bid = awid;
            next_bresp = `TLBR_RESP_SLVERR;
            if (wr_sec) begin
                next_bresp = `TLBR_RESP_OKAY;
                case (awaddr)
                    ADDR_W'(`TLBR_OFF_BU_PTR): begin
                        next_bu_ptr = merge(bu_ptr, wdata, wstrb);
                    end
                    ADDR_W'(`TLBR_OFF_TC_PTR): begin
                        next_tc_ptr = merge(tc_ptr, wdata, wstrb);
                    end
                    // data registers are read-only: the write is acknowledged and dropped
                    ADDR_W'(`TLBR_OFF_BU_DATA), ADDR_W'(`TLBR_OFF_TC_DATA): begin
                        next_bresp = `TLBR_RESP_OKAY;
                    end
                    default: next_bresp = `TLBR_RESP_DECERR;
                endcase
            end
        end
        case (state)
            TLBR_IDLE: begin
                if (ar_take) begin
                    next_rid = arid;
                    next_rsel_fmt = 1'b0;
                    next_rreg = `TLBR_ZERO_WORD;
                    next_rresp = `TLBR_RESP_SLVERR;
                    next_state = TLBR_RESP;
                    if (rd_sec) begin
                        next_rresp = `TLBR_RESP_OKAY;
                        case (araddr)
                            ADDR_W'(`TLBR_OFF_BU_PTR): next_rreg = bu_ptr;
                            ADDR_W'(`TLBR_OFF_TC_PTR): next_rreg = tc_ptr;
                            ADDR_W'(`TLBR_OFF_BU_DATA): begin
                                next_fetch = '0;
                                next_fetch.unit = bu_ptr.unit;
                                next_fetch.entry = bu_ptr.entry;
                                next_fetch.word = bu_ptr.word[3:2];
                                next_oob = 32'(bu_ptr.unit) >= NUM_UNITS ||
                                           32'(bu_ptr.entry) >= BU_ENTRIES;
                                next_rsel_fmt = 1'b1;
                                next_state = TLBR_FETCH;
                            end
                            ADDR_W'(`TLBR_OFF_TC_DATA): begin
                                next_fetch = '0;
                                next_fetch.side = 1'b1;
                                next_fetch.src = tc_ptr.src;
                                next_fetch.way = tc_ptr.way;
                                next_fetch.entry = tc_ptr.entry;
                                next_fetch.word = tc_ptr.word[3:2];
                                next_oob = 32'(tc_ptr.entry) >= TC_ENTRIES;
                                next_rsel_fmt = 1'b1;
                                next_state = TLBR_FETCH;
                            end
                            default: next_rresp = `TLBR_RESP_DECERR;
                        endcase
                    end
                end
            end
            TLBR_FETCH: begin
                // word and entry fields form one counter; entry wraps without touching 31:16
                if (cache_fetch.side) begin
                    next_tc_ptr[15:0] = tc_ptr[15:0] + `TLBR_PTR_STEP;
                end else begin
                    next_bu_ptr[15:0] = bu_ptr[15:0] + `TLBR_PTR_STEP;
                end
                next_state = TLBR_FMT;
            end
            TLBR_FMT: next_state = TLBR_RESP;
            TLBR_RESP: begin
                if (rready) begin
                    next_state = TLBR_IDLE;
                end
            end
            default: next_state = TLBR_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= TLBR_IDLE;
            bu_ptr <= `TLBR_PTR_RST;
            tc_ptr <= `TLBR_PTR_RST;
            cache_fetch <= '0;
            oob <= 1'b0;
            rsel_fmt <= 1'b0;
            rreg <= `TLBR_ZERO_WORD;
            rresp <= `TLBR_RESP_OKAY;
            rid <= '0;
            bvalid <= 1'b0;
            bresp <= `TLBR_RESP_OKAY;
            bid <= '0;
        end else if (ce) begin
            state <= next_state;
            bu_ptr <= next_bu_ptr;
            tc_ptr <= next_tc_ptr;
            cache_fetch <= next_fetch;
            oob <= next_oob;
            rsel_fmt <= next_rsel_fmt;
            rreg <= next_rreg;
            rresp <= next_rresp;
            rid <= next_rid;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            bid <= next_bid;
        end
    end

    // cache answers while in the format state
    tlbr_word_fmt u_fmt (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .load(state == TLBR_FMT),
        .oob(oob),
        .first_entry(cache_fetch.entry == 12'h000),
        .word(cache_fetch.word),
        .entry(cache_entry),
        .word_out(fmt_word)
    );

    default clocking main_cb @(posedge clk iff ce);
    endclocking
    default disable iff (rst);

    sequence data_read_taken;
        ar_take && rd_sec && (araddr == ADDR_W'(`TLBR_OFF_BU_DATA) ||
                              araddr == ADDR_W'(`TLBR_OFF_TC_DATA));
    endsequence

    sequence fetch_then_answer;
        cache_req ##1 !rvalid ##1 rvalid && rresp == `TLBR_RESP_OKAY;
    endsequence

    chk_fetch_then_answer: assert property (data_read_taken |=> fetch_then_answer)
        else $error("data read did not fetch and answer in three cycles");
    chk_step_four_bytes: assert property (cache_req && !cache_fetch.side |=>
        bu_ptr[15:0] == $past(bu_ptr[15:0]) + `TLBR_PTR_STEP &&
        bu_ptr[31:16] == $past(bu_ptr[31:16]))
        else $error("buffer pointer did not advance by one word");
    chk_tc_step: assert property (cache_req && cache_fetch.side |=>
        tc_ptr[15:0] == $past(tc_ptr[15:0]) + `TLBR_PTR_STEP && $stable(bu_ptr))
        else $error("walk pointer advance wrong");
    chk_low_bits_zero: assert property (bu_ptr[1:0] == 2'h0 && tc_ptr[1:0] == 2'h0)
        else $error("pointer low bits not zero");
    chk_data_write_ignored: assert property (wr_take &&
        (awaddr == ADDR_W'(`TLBR_OFF_BU_DATA) || awaddr == ADDR_W'(`TLBR_OFF_TC_DATA)) |=>
        $stable(bu_ptr) && $stable(tc_ptr))
        else $error("data register write changed a pointer");
    chk_nonsecure_blocked: assert property (ar_take && !rd_sec |=>
        rvalid && rdata == `TLBR_ZERO_WORD && rresp == `TLBR_RESP_SLVERR)
        else $error("non-secure read not refused");
    chk_pointer_write: assert property (wr_take && wr_sec && wstrb == 4'hF &&
        awaddr == ADDR_W'(`TLBR_OFF_BU_PTR) |=> bu_ptr == ($past(wdata) & `TLBR_LOW_MASK))
        else $error("buffer pointer write not stored");
    chk_oob_zero: assert property (rvalid && rsel_fmt && oob |-> rdata == `TLBR_ZERO_WORD)
        else $error("out-of-bounds read returned data");
    chk_answer_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped before accepted");

    sequence bu_data_taken;
        ar_take && rd_sec && araddr == ADDR_W'(`TLBR_OFF_BU_DATA);
    endsequence

    sequence tc_data_taken;
        ar_take && rd_sec && araddr == ADDR_W'(`TLBR_OFF_TC_DATA);
    endsequence

    // the cache port must see the pointer as it stood when the read was taken,
    // not the advanced value written back one cycle later
    chk_bu_fetch_fields: assert property (bu_data_taken |=>
        !cache_fetch.side &&
        cache_fetch.unit == $past(bu_ptr.unit) &&
        cache_fetch.entry == $past(bu_ptr.entry) &&
        cache_fetch.word == $past(bu_ptr.word[3:2]))
        else $error("buffer fetch does not match the pointer");

    chk_tc_fetch_source: assert property (tc_data_taken |=>
        cache_fetch.side &&
        cache_fetch.src == $past(tc_ptr.src) &&
        cache_fetch.way == $past(tc_ptr.way))
        else $error("walk fetch source or way wrong");

    chk_tc_ptr_write: assert property (wr_take && wr_sec && wstrb == 4'hF &&
        awaddr == ADDR_W'(`TLBR_OFF_TC_PTR) |=> tc_ptr == ($past(wdata) & `TLBR_LOW_MASK))
        else $error("walk pointer write not stored");

    chk_bu_readback: assert property (ar_take && rd_sec &&
        araddr == ADDR_W'(`TLBR_OFF_BU_PTR) |=> rvalid && rdata == $past(bu_ptr))
        else $error("buffer pointer read back wrong");

    chk_tc_readback: assert property (ar_take && rd_sec &&
        araddr == ADDR_W'(`TLBR_OFF_TC_PTR) |=> rvalid && rdata == $past(tc_ptr))
        else $error("walk pointer read back wrong");

    // a refused write must leave both pointers as they were
    chk_nonsecure_write: assert property (wr_take && !wr_sec |=>
        bresp == `TLBR_RESP_SLVERR && $stable(bu_ptr) && $stable(tc_ptr))
        else $error("non-secure write not refused");

    chk_write_answer: assert property (wr_take |=> bvalid && bid == $past(awid))
        else $error("write response missing or wrong id");

    chk_read_id: assert property (ar_take |=> rid == $past(arid) && rlast)
        else $error("read id not echoed");

endmodule

// >>> hw/tlbr_cfg.svh
// constants for the translation cache debug readout
// Contract
// - data read returns selected word, pointer advances
// - each advance adds four bytes
// - fetched word returned on programming port
// - pointers writable, data registers read-only
// - pointer bits 1:0 read zero
// - out-of-bounds pointer reads return zero
// - only secure accesses reach these registers
// - buffer-unit pair at 0x80 and 0x84
// - walk-unit pair at 0x88 and 0x8C
// - data register is 32-bit addressed word
// - pointer bits 31:16 zero unless written
// - buffer-unit selector in bits 31:24
// - entry index 15:4, word index 3:0
// - walk-unit bits 27:26 pick read source
// - walk-unit bits 25:24 pick way RAM
// - word 0 bits 31:4 hold lookup address
// - word position code marks first/last/middle
// - bit 1 flags pointer invalid
// - bit 0 flags word content invalid
// - parity-corrupt invalid entries need no correction
// - word 1 bits 31:16 hold address tag
// - word 2 bits 31:4 hold physical address
`ifndef TLBR_CFG_SVH
`define TLBR_CFG_SVH

`define TLBR_OFF_BU_PTR 8'h80
`define TLBR_OFF_BU_DATA 8'h84
`define TLBR_OFF_TC_PTR 8'h88
`define TLBR_OFF_TC_DATA 8'h8C

`define TLBR_PTR_RST 32'h0000_0000
`define TLBR_PTR_STEP 16'h0004
`define TLBR_LOW_MASK 32'hFFFF_FFFC
`define TLBR_ZERO_WORD 32'h0000_0000

`define TLBR_POS_MID 2'h0
`define TLBR_POS_FIRST 2'h1
`define TLBR_POS_LAST 2'h2
`define TLBR_POS_CACHE 2'h3
`define TLBR_WORD_VA 2'h0
`define TLBR_WORD_TAG 2'h1
`define TLBR_WORD_PA 2'h2
`define TLBR_WORD_LAST 2'h3

`define TLBR_RESP_OKAY 2'h0
`define TLBR_RESP_SLVERR 2'h2
`define TLBR_RESP_DECERR 2'h3
`define TLBR_PROT_NS 1

`endif

// >>> hw/tlbr_pkg.sv
// types shared by the translation cache debug readout
package tlbr_pkg;

    typedef struct packed {
        logic [7:0] unit;
        logic [7:0] rsv;
        logic [11:0] entry;
        logic [3:0] word;
    } tlbr_bu_ptr_t;

    typedef struct packed {
        logic [3:0] rsv_hi;
        logic [1:0] src;
        logic [1:0] way;
        logic [7:0] rsv;
        logic [11:0] entry;
        logic [3:0] word;
    } tlbr_tc_ptr_t;

    typedef struct packed {
        logic side;
        logic [7:0] unit;
        logic [1:0] src;
        logic [1:0] way;
        logic [11:0] entry;
        logic [1:0] word;
    } tlbr_fetch_t;

    typedef struct packed {
        logic word_bad;
        logic ptr_bad;
        logic [27:0] va;
        logic [15:0] address_space_tag;
        logic [11:0] attr;
        logic [27:0] pa;
        logic [27:0] extra;
    } tlbr_entry_t;

    typedef enum logic [1:0] {
        TLBR_IDLE,
        TLBR_FETCH,
        TLBR_FMT,
        TLBR_RESP
    } tlbr_state_t;

endpackage

// >>> hw/tlbr_word_fmt.sv
// packs one cache entry word into the debug read data layout
`timescale 1ns/1ps
`include "tlbr_cfg.svh"
module tlbr_word_fmt
    import tlbr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // request
    input wire logic load,
    input wire logic oob,
    input wire logic first_entry,
    input wire logic [1:0] word,
    input wire tlbr_entry_t entry,
    // packed word
    output logic [31:0] word_out
);

    logic [31:0] next_word_out;
    logic [1:0] pos;
    logic [27:0] body;

    always_comb begin
        pos = `TLBR_POS_MID;
        if (word == `TLBR_WORD_VA) begin
            pos = first_entry ? `TLBR_POS_CACHE : `TLBR_POS_FIRST;
        end else if (word == `TLBR_WORD_LAST) begin
            pos = `TLBR_POS_LAST;
        end
        next_word_out = word_out;
        body = entry.extra;
        if (load) begin
            // parity faults on invalid entries pass through untouched
            case (word)
                `TLBR_WORD_VA: body = entry.va;
                `TLBR_WORD_TAG: body = {entry.address_space_tag, entry.attr};
                `TLBR_WORD_PA: body = entry.pa;
                default: body = entry.extra;
            endcase
            next_word_out = {body, pos, entry.ptr_bad, entry.word_bad};
            if (oob) begin
                next_word_out = `TLBR_ZERO_WORD;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            word_out <= `TLBR_ZERO_WORD;
        end else if (ce) begin
            word_out <= next_word_out;
        end
    end

    default clocking fmt_cb @(posedge clk iff ce);
    endclocking
    default disable iff (rst);

    chk_fmt_first_va: assert property (load && !oob && word == `TLBR_WORD_VA |=>
        word_out[31:4] == $past(entry.va) && word_out[3:2] != `TLBR_POS_MID)
        else $error("word 0 does not carry lookup address");
    chk_fmt_last_code: assert property (load && !oob && word == `TLBR_WORD_LAST |=>
        word_out[3:2] == `TLBR_POS_LAST && word_out[0] == $past(entry.word_bad))
        else $error("last word position code or word flag wrong");

endmodule

// >>> dv/tlbr_cache_model.sv
// behavioural translation cache answering the debug read port
`timescale 1ns/1ps
module tlbr_cache_model
    import tlbr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // cache read port
    input wire logic cache_req,
    input wire tlbr_fetch_t cache_fetch,
    output tlbr_entry_t cache_entry
);
    // contents are a fixed function of the location, so the bench can predict them
    function automatic tlbr_entry_t mk(input tlbr_fetch_t f);
        logic [7:0] sel;
        sel = f.side ? {4'h0, f.src, f.way} : f.unit;
        mk.va = {4'hA, sel, f.entry, 4'h6};
        mk.address_space_tag = {4'h5, f.entry};
        mk.attr = 12'hC35;
        mk.pa = ~{4'hA, sel, f.entry, 4'h6};
        mk.extra = {f.entry, 16'hBEEF};
        mk.word_bad = f.entry[0];
        mk.ptr_bad = f.entry[1];
    endfunction
    // no update runs beside a debug read; outside the answer the data keeps moving
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cache_entry <= '0;
        end else if (cache_req) begin
            cache_entry <= mk(cache_fetch);
        end else begin
            cache_entry <= ~cache_entry;
        end
    end
endmodule

// >>> dv/tlb_debug_readout_bench.sv
// self-checking bench for the translation cache debug readout
`timescale 1ns/1ps
module tlb_debug_readout_bench;
    import tlbr_pkg::*;
    logic clk, rst, ce, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, rlast, cache_req;
    logic [7:0] awaddr, araddr;
    logic [3:0] awid, bid, arid, rid, wstrb;
    logic [2:0] awprot, arprot;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    tlbr_fetch_t cache_fetch;
    tlbr_entry_t cache_entry;
    int num_errors = 0;
    int n_checks = 0;

    tlbr_debug_readout #(.ADDR_W(8), .ID_W(4), .NUM_UNITS(8), .BU_ENTRIES(64),
        .TC_ENTRIES(512)) i_dut (.clk(clk), .rst(rst), .ce(ce), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .awid(awid), .awprot(awprot),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .bid(bid),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arid(arid),
        .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .rid(rid), .rlast(rlast), .cache_req(cache_req),
        .cache_fetch(cache_fetch), .cache_entry(cache_entry));
    tlbr_cache_model i_cache (.clk(clk), .rst(rst), .cache_req(cache_req),
        .cache_fetch(cache_fetch), .cache_entry(cache_entry));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t resp got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_id(input logic [3:0] got, input logic [3:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t id got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t flag got=%h exp=%h", $time, got, exp);
        end
    endtask

    // waits on the settled level mid-cycle; a hang ends the run
    task automatic wait_hi(input int sel);
        int i;
        for (i = 0; i < 50; i++) begin
            @(negedge clk);
            if (sel == 0 && awready === 1'b1) break;
            if (sel == 1 && bvalid === 1'b1) break;
            if (sel == 2 && arready === 1'b1) break;
            if (sel == 3 && rvalid === 1'b1) break;
        end
        if (i == 50) begin
            num_errors++;
            print_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [2:0] p, input logic [1:0] exp_r);
        awaddr = a;
        wdata = d;
        wstrb = s;
        awprot = p;
        awid = a[5:2];
        awvalid = 1'b1;
        wvalid = 1'b1;
        wait_hi(0);
        @(posedge clk);
        #1;
        awvalid = 1'b0;
        wvalid = 1'b0;
        wait_hi(1);
        chk_resp(bresp, exp_r);
        chk_id(bid, a[5:2]);
        @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [2:0] p, input logic [31:0] exp_d,
        input logic [1:0] exp_r);
        araddr = a;
        arprot = p;
        arid = a[5:2];
        arvalid = 1'b1;
        wait_hi(2);
        @(posedge clk);
        #1;
        arvalid = 1'b0;
        wait_hi(3);
        chk_word(rdata, exp_d);
        chk_resp(rresp, exp_r);
        chk_id(rid, a[5:2]);
        chk_flag(rlast, 1'b1);
        @(posedge clk);
        #1;
    endtask

    function automatic logic [31:0] exp_word(input logic side, input logic [31:0] ptr);
        tlbr_fetch_t f;
        tlbr_entry_t e;
        logic [3:0] low;
        f = '{side, side ? 8'h00 : ptr[31:24], ptr[27:26], ptr[25:24], ptr[15:4], ptr[3:2]};
        e = i_cache.mk(f);
        low[1:0] = {e.ptr_bad, e.word_bad};
        low[3:2] = (f.word == 2'h3) ? 2'h2 : 2'h0;
        if (f.word == 2'h0) low[3:2] = (f.entry == 12'h000) ? 2'h3 : 2'h1;
        case (f.word)
            2'h0: exp_word = {e.va, low};
            2'h1: exp_word = {e.address_space_tag, e.attr, low};
            2'h2: exp_word = {e.pa, low};
            default: exp_word = {e.extra, low};
        endcase
    endfunction

    task automatic t_reset;
        rd(8'h80, 3'h0, 32'h0000_0000, 2'h0);
        rd(8'h88, 3'h0, 32'h0000_0000, 2'h0);
    endtask

    // low bits ignored, byte lanes merged, out-of-range entry still advances
    task automatic t_ptr_write;
        wr(8'h80, 32'h0300_0013, 4'hF, 3'h0, 2'h0);
        rd(8'h80, 3'h0, 32'h0300_0010, 2'h0);
        wr(8'h80, 32'hFFFF_FFFF, 4'h2, 3'h0, 2'h0);
        rd(8'h84, 3'h0, 32'h0000_0000, 2'h0);
        rd(8'h80, 3'h0, 32'h0300_FF14, 2'h0);
        wr(8'h84, 32'h1234_5678, 4'hF, 3'h0, 2'h0);
        rd(8'h80, 3'h0, 32'h0300_FF14, 2'h0);
    endtask

    // word 2 of entry 1 onwards: crosses the entry boundary
    task automatic t_bu_walk;
        logic [31:0] p;
        p = 32'h0300_0018;
        wr(8'h80, p, 4'hF, 3'h0, 2'h0);
        repeat (4) begin
            rd(8'h84, 3'h0, exp_word(1'b0, p), 2'h0);
            p = p + 32'h4;
        end
        rd(8'h80, 3'h0, 32'h0300_0028, 2'h0);
        wr(8'h80, 32'h0700_03FC, 4'hF, 3'h0, 2'h0);
        rd(8'h84, 3'h0, exp_word(1'b0, 32'h0700_03FC), 2'h0);
        rd(8'h84, 3'h0, 32'h0000_0000, 2'h0);
        wr(8'h80, 32'h0800_0000, 4'hF, 3'h0, 2'h0);
        rd(8'h84, 3'h0, 32'h0000_0000, 2'h0);
    endtask

    // every read source and way, first word of the cache included
    task automatic t_tc_src;
        logic [31:0] p;
        for (int k = 0; k < 16; k++) begin
            p = {4'h0, k[3:0], 8'h00, 8'h00, k[3:0], 4'h0};
            wr(8'h88, p, 4'hF, 3'h0, 2'h0);
            rd(8'h8C, 3'h0, exp_word(1'b1, p), 2'h0);
        end
        wr(8'h88, 32'h0000_2000, 4'hF, 3'h0, 2'h0);
        rd(8'h8C, 3'h0, 32'h0000_0000, 2'h0);
    endtask

    // answer must stand under back-pressure and while the clock enable is low
    task automatic t_hold;
        logic [31:0] e;
        e = exp_word(1'b1, 32'h0000_0010);
        wr(8'h88, 32'h0000_0010, 4'hF, 3'h0, 2'h0);
        rready = 1'b0;
        rd(8'h8C, 3'h0, e, 2'h0);
        repeat (2) @(posedge clk);
        #1;
        ce = 1'b0;
        rready = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk_flag(rvalid, 1'b1);
        chk_word(rdata, e);
        ce = 1'b1;
        @(posedge clk);
        #1;
        chk_flag(rvalid, 1'b0);
        rd(8'h88, 3'h0, 32'h0000_0014, 2'h0);
    endtask

    // non-secure traffic refused without side effects; unmapped decode error
    task automatic t_secure;
        wr(8'h88, 32'h0000_0050, 4'hF, 3'h0, 2'h0);
        wr(8'h88, 32'h0000_0120, 4'hF, 3'h2, 2'h2);
        rd(8'h8C, 3'h2, 32'h0000_0000, 2'h2);
        rd(8'h88, 3'h2, 32'h0000_0000, 2'h2);
        rd(8'h88, 3'h0, 32'h0000_0050, 2'h0);
        rd(8'h90, 3'h0, 32'h0000_0000, 2'h3);
        wr(8'h90, 32'hFFFF_FFFF, 4'hF, 3'h0, 2'h3);
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        bready = 1'b1;
        rready = 1'b1;
        {awvalid, wvalid, arvalid, awaddr, araddr, awid, arid} = '0;
        {awprot, arprot, wdata, wstrb} = '0;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_ptr_write();
        t_bu_walk();
        t_tc_src();
        t_hold();
        t_secure();
        print_verdict();
    end
endmodule
